// ---- pkg/plpc_params.svh ----
// Constants of the phased LED PWM configuration block.
// Assumes a single 20 MHz clock; included by every design file.
`ifndef PLPC_PARAMS_SVH
`define PLPC_PARAMS_SVH

// Clock and PWM timing base
`define PLPC_CLK_HZ 64'd20000000
`define PLPC_FREQ_STEP_HZ 64'd1202
`define PLPC_ACC_W 24
`define PLPC_ACC_FULL 64'd16777216
`define PLPC_PHASE_STEP ((`PLPC_FREQ_STEP_HZ * `PLPC_ACC_FULL) / `PLPC_CLK_HZ)
`define PLPC_TURN_DEG 360

// Dimming resolutions in bits
`define PLPC_RES10_W 10
`define PLPC_RES9_W 9
`define PLPC_RES8_W 8

// Register indices; byte address is four times the index
`define PLPC_IDX_PWM_CFG 8'ha5
`define PLPC_IDX_BOOST_CFG 8'ha6
`define PLPC_PWM_CFG_RST 8'h00
`define PLPC_BOOST_CFG_RST 8'h00

// Field positions
`define PLPC_DIRECT_BIT 7
`define PLPC_PSS_MSB 6
`define PLPC_PSS_LSB 4
`define PLPC_DFS_MSB 3
`define PLPC_DFS_LSB 0
`define PLPC_BSR_MSB 7
`define PLPC_BSR_LSB 6
`define PLPC_BVT_MSB 5
`define PLPC_BVT_LSB 0

// Phase modes: two-phase and grouped drivers
`define PLPC_MODE_2PH 3'h4
`define PLPC_MODE_3X2 3'h5
`define PLPC_MODE_2X3 3'h6
`define PLPC_MODE_1X6 3'h7

// Boost switching rates
`define PLPC_RATE_312 2'h0
`define PLPC_RATE_625 2'h1
`define PLPC_RATE_1250 2'h2
`define PLPC_BOOST_312_KHZ 64'd312
`define PLPC_BOOST_625_KHZ 64'd625
`define PLPC_BOOST_1250_KHZ 64'd1250
`define PLPC_KHZ 64'd1000

`endif

// ---- pkg/plpc_pkg.sv ----
// Types shared by the phased LED PWM configuration block.
// Assumes nothing beyond a SystemVerilog package scope.
`default_nettype none
package plpc_pkg;
  // Register bus handshake states
  typedef enum logic {PLPC_BUS_IDLE, PLPC_BUS_ACK} plpc_bus_state_t;
  // Dimming resolution classes
  typedef enum logic [1:0] {PLPC_RES10, PLPC_RES9, PLPC_RES8} plpc_res_t;
endpackage
`default_nettype wire

// ---- design/plpc_phase_acc.sv ----
// Phase accumulator that sets the PWM frame rate.
// Assumes the multiplier is the frame rate in steps of the base rate.
`timescale 1ns/1ps
`default_nettype none
`include "plpc_params.svh"
module plpc_phase_acc (
  input wire logic clk_i, // System clock
  input wire logic reset_i, // Synchronous reset
  input wire logic ce_i, // Clock enable
  input wire logic [5:0] mult_i, // Rate in base steps
  output logic [`PLPC_ACC_W-1:0] acc_o // Frame phase
);
  logic [`PLPC_ACC_W-1:0] next_acc; // Advanced phase

  // Step derived from clock, so wrap rate is mult times base rate
  assign next_acc = acc_o + `PLPC_ACC_W'(64'(mult_i) * `PLPC_PHASE_STEP);

  // Phase register; wraps once per PWM frame
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      acc_o <= '0;
    end else if (ce_i) begin
      acc_o <= next_acc;
    end
  end
endmodule
`default_nettype wire

// ---- design/plpc_boost_clk.sv ----
// Divider producing the boost switching clock.
// Assumes the rate code is already resolved between register and resistor.
`timescale 1ns/1ps
`default_nettype none
`include "plpc_params.svh"
module plpc_boost_clk (
  input wire logic clk_i, // System clock
  input wire logic reset_i, // Synchronous reset
  input wire logic ce_i, // Clock enable
  input wire logic [1:0] rate_i, // Resolved rate code
  output logic boost_clk_o // Switching clock
);
  // Half periods in system cycles
  localparam logic [6:0] HALF_312 = 7'(`PLPC_CLK_HZ / (`PLPC_BOOST_312_KHZ * `PLPC_KHZ * 64'd2));
  localparam logic [6:0] HALF_625 = 7'(`PLPC_CLK_HZ / (`PLPC_BOOST_625_KHZ * `PLPC_KHZ * 64'd2));
  localparam logic [6:0] HALF_1250 = 7'(`PLPC_CLK_HZ / (`PLPC_BOOST_1250_KHZ * `PLPC_KHZ * 64'd2));
  logic [6:0] half; // Selected half period
  logic [6:0] cnt; // Cycles in this half

  // Undefined code falls back to the slowest rate, the safest for the coil
  always_comb begin
    case (rate_i)
      `PLPC_RATE_625: half = HALF_625;
      `PLPC_RATE_1250: half = HALF_1250;
      default: half = HALF_312;
    endcase
  end

  // Count and toggle; >= keeps a rate change from overrunning
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt <= '0;
      boost_clk_o <= 1'b0;
    end else if (ce_i) begin
      if (cnt >= half - 7'h01) begin
        cnt <= '0;
        boost_clk_o <= ~boost_clk_o;
      end else begin
        cnt <= cnt + 7'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ---- design/plpc_top.sv ----
// Phased LED PWM configuration: registers, phase-shifted outputs, boost setup.
// Assumes an Avalon-MM master, a 10-bit brightness from the dimming pipeline,
// and raw PWM on the bypass input.
// How it works
// - Codes 0-4 run 6..2 spaced phases, rest off
// - Codes 5,6,7 give pairs, triples, all in phase
// - Frequency codes 0-4 give 4808..9616 Hz, 10-bit
// - Codes 5-B step 1202 Hz; C-F reach 38464 Hz
// - Direct bit bypasses dimming onto the outputs
// - Boost rate 312/625/1250 kHz unless resistor selects
// - Boost voltage field; minimum and start when adaptive
`timescale 1ns/1ps
`default_nettype none
`include "plpc_params.svh"
module plpc_top (
  input wire logic clk_i, // 20 MHz clock
  input wire logic reset_i, // Synchronous reset, high
  input wire logic ce_i, // Clock enable, freezes state
  input wire logic [9:0] avs_address_i, // Byte address
  input wire logic avs_read_i, // Read request
  input wire logic avs_write_i, // Write request
  input wire logic [3:0] avs_byteenable_i, // Byte lanes
  input wire logic [31:0] avs_writedata_i, // Write data
  output logic [31:0] avs_readdata_o, // Read data
  output logic avs_waitrequest_o, // Stall, high
  input wire logic [9:0] duty_i, // Brightness from pipeline
  input wire logic pwm_direct_i, // Raw PWM for bypass
  input wire logic resistor_rate_enable_i, // Rate set by resistor
  input wire logic [1:0] resistor_rate_i, // Rate from resistor
  input wire logic adaptive_enable_i, // Adaptive voltage on
  output logic [5:0] led_pwm_o, // Driver PWM outputs
  output logic boost_clk_o, // Boost switching clock
  output logic [5:0] boost_voltage_target_o, // Boost voltage code
  output logic boost_voltage_floor_o // Code is min and start
);
  plpc_pkg::plpc_bus_state_t bus_state; // Handshake state
  logic [7:0] pwm_output_config; // Direct, phase, frequency
  logic [7:0] boost_setting_config; // Rate and voltage
  logic hit_pwm; // Address hits PWM config
  logic hit_boost; // Address hits boost config
  logic [7:0] read_value; // Selected read byte
  logic direct_pwm; // Bypass mode
  logic [2:0] phase_shift_select; // Phase mode
  logic [3:0] dimming_frequency_select; // Frame rate code
  logic [1:0] boost_switching_rate; // Register rate code
  logic [1:0] rate_sel; // Resolved rate code
  logic [5:0] mult; // Rate in base steps
  logic [`PLPC_ACC_W-1:0] acc; // Frame phase
  logic [5:0] chan_on; // Dimmed channel levels
  logic [5:0] chan_mask; // Channels in use
  plpc_pkg::plpc_res_t res; // Active resolution

  // Field views of the two registers
  assign direct_pwm = pwm_output_config[`PLPC_DIRECT_BIT];
  assign phase_shift_select = pwm_output_config[`PLPC_PSS_MSB:`PLPC_PSS_LSB];
  assign dimming_frequency_select = pwm_output_config[`PLPC_DFS_MSB:`PLPC_DFS_LSB];
  assign boost_switching_rate = boost_setting_config[`PLPC_BSR_MSB:`PLPC_BSR_LSB];

  // Frame rate as a multiple of the 1202 Hz base
  function automatic logic [5:0] freq_mult(input logic [3:0] code);
    case (code)
      4'h0: freq_mult = 6'h04;
      4'h1: freq_mult = 6'h05;
      4'h2: freq_mult = 6'h06;
      4'h3: freq_mult = 6'h07;
      4'h4: freq_mult = 6'h08;
      4'hc: freq_mult = 6'h14;
      4'hd: freq_mult = 6'h18;
      4'he: freq_mult = 6'h1c;
      4'hf: freq_mult = 6'h20;
      default: freq_mult = 6'(code) + 6'h05; // Codes 5..b: 10..16 steps
    endcase
  endfunction

  // Resolution class of a frequency code
  function automatic plpc_pkg::plpc_res_t res_of(input logic [3:0] code);
    if (code <= 4'h4) begin
      res_of = plpc_pkg::PLPC_RES10;
    end else if (code <= 4'hb) begin
      res_of = plpc_pkg::PLPC_RES9;
    end else begin
      res_of = plpc_pkg::PLPC_RES8;
    end
  endfunction

  // Phase angle in degrees of one channel under a mode
  function automatic logic [8:0] chan_deg(input logic [2:0] mode, input int ch);
    int n;
    n = 6 - int'(mode);
    case (mode)
      `PLPC_MODE_3X2: chan_deg = 9'((ch / 2) * 120);
      `PLPC_MODE_2X3: chan_deg = 9'((ch / 3) * 180);
      `PLPC_MODE_1X6: chan_deg = 9'h000;
      default: chan_deg = 9'((ch * `PLPC_TURN_DEG) / n);
    endcase
  endfunction

  // Whether a channel runs under a mode
  function automatic logic chan_used(input logic [2:0] mode, input int ch);
    if (mode > `PLPC_MODE_2PH) begin
      chan_used = 1'b1;
    end else begin
      chan_used = ch < (6 - int'(mode));
    end
  endfunction

  // Register decode, used by both read and write paths
  function automatic logic addr_is(input logic [9:0] addr, input logic [7:0] idx);
    addr_is = addr == {idx, 2'b00};
  endfunction

  assign hit_pwm = addr_is(avs_address_i, `PLPC_IDX_PWM_CFG);
  assign hit_boost = addr_is(avs_address_i, `PLPC_IDX_BOOST_CFG);
  assign mult = freq_mult(dimming_frequency_select);
  assign res = res_of(dimming_frequency_select);

  // Read mux; unmapped addresses read zero
  always_comb begin
    if (hit_pwm) begin
      read_value = pwm_output_config;
    end else if (hit_boost) begin
      read_value = boost_setting_config;
    end else begin
      read_value = 8'h00;
    end
  end

  // Stall first cycle of every request; frozen clock keeps the stall
  assign avs_waitrequest_o = !(bus_state == plpc_pkg::PLPC_BUS_ACK && ce_i);

  // Two-cycle handshake: capture in idle, complete in ack
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bus_state <= plpc_pkg::PLPC_BUS_IDLE;
    end else if (ce_i) begin
      case (bus_state)
        plpc_pkg::PLPC_BUS_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            bus_state <= plpc_pkg::PLPC_BUS_ACK;
          end
        end
        plpc_pkg::PLPC_BUS_ACK: bus_state <= plpc_pkg::PLPC_BUS_IDLE;
        default: bus_state <= plpc_pkg::PLPC_BUS_IDLE;
      endcase
    end
  end

  // Read data registered in the stall cycle, stands through the ack edge
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (ce_i && bus_state == plpc_pkg::PLPC_BUS_IDLE && avs_read_i) begin
      avs_readdata_o <= {24'h00_0000, read_value};
    end
  end

  // Register writes land at the ack edge; only the low lane holds data
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pwm_output_config <= `PLPC_PWM_CFG_RST;
      boost_setting_config <= `PLPC_BOOST_CFG_RST;
    end else if (ce_i && bus_state == plpc_pkg::PLPC_BUS_ACK && avs_write_i && avs_byteenable_i[0]) begin
      if (hit_pwm) begin
        pwm_output_config <= avs_writedata_i[7:0];
      end
      if (hit_boost) begin
        boost_setting_config <= avs_writedata_i[7:0];
      end
    end
  end

  // Frame phase shared by all channels
  plpc_phase_acc u_acc (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .mult_i(mult),
    .acc_o(acc)
  );

  // Per-channel compare of shifted phase against brightness
  for (genvar g = 0; g < 6; g++) begin : g_chan
    logic [`PLPC_ACC_W-1:0] offset; // Phase offset of channel
    logic [`PLPC_ACC_W-1:0] pos; // Shifted phase
    assign offset = `PLPC_ACC_W'((64'(chan_deg(phase_shift_select, g)) * `PLPC_ACC_FULL) / `PLPC_TURN_DEG);
    assign pos = acc - offset;
    logic lit; // Level of this channel, one process per bit
    assign chan_mask[g] = chan_used(phase_shift_select, g);
    // Local level keeps each comb process the only writer of its variable
    always_comb begin
      case (res)
        plpc_pkg::PLPC_RES9: lit = pos[`PLPC_ACC_W-1 -: `PLPC_RES9_W] < duty_i[9:1];
        plpc_pkg::PLPC_RES8: lit = pos[`PLPC_ACC_W-1 -: `PLPC_RES8_W] < duty_i[9:2];
        default: lit = pos[`PLPC_ACC_W-1 -: `PLPC_RES10_W] < duty_i;
      endcase
    end
    assign chan_on[g] = lit;
  end

  // Outputs: dimmed phases, or raw PWM in bypass; unused drivers off
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      led_pwm_o <= 6'h00;
    end else if (ce_i) begin
      if (direct_pwm) begin
        led_pwm_o <= {6{pwm_direct_i}} & chan_mask;
      end else begin
        led_pwm_o <= chan_on & chan_mask;
      end
    end
  end

  // Resistor overrides the register rate when enabled
  assign rate_sel = resistor_rate_enable_i ? resistor_rate_i : boost_switching_rate;

  plpc_boost_clk u_boost (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .rate_i(rate_sel),
    .boost_clk_o(boost_clk_o)
  );

  // Voltage code; in adaptive mode it is the floor and start point
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      boost_voltage_target_o <= 6'h00;
      boost_voltage_floor_o <= 1'b0;
    end else if (ce_i) begin
      boost_voltage_target_o <= boost_setting_config[`PLPC_BVT_MSB:`PLPC_BVT_LSB];
      boost_voltage_floor_o <= adaptive_enable_i;
    end
  end

  // Two-phase mode leaves drivers 2..5 dark
  property p_two_phase_off;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && $past(ce_i) && $past(phase_shift_select) == `PLPC_MODE_2PH) |-> led_pwm_o[5:2] == 4'h0;
  endproperty
  a_two_phase_off: assert property (p_two_phase_off) else $error("unused drivers active");

  // Pairs mode keeps each pair equal
  property p_pairs;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && $past(ce_i) && !$past(direct_pwm) && $past(phase_shift_select) == `PLPC_MODE_3X2)
      |-> (led_pwm_o[0] == led_pwm_o[1]) && (led_pwm_o[2] == led_pwm_o[3]) && (led_pwm_o[4] == led_pwm_o[5]);
  endproperty
  a_pairs: assert property (p_pairs) else $error("pair outputs differ");

  // Triples mode keeps each group equal
  property p_triples;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && $past(ce_i) && !$past(direct_pwm) && $past(phase_shift_select) == `PLPC_MODE_2X3)
      |-> (led_pwm_o[2:0] == {3{led_pwm_o[0]}}) && (led_pwm_o[5:3] == {3{led_pwm_o[3]}});
  endproperty
  a_triples: assert property (p_triples) else $error("triple outputs differ");

  // Single-phase mode: all six equal
  property p_in_phase;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && $past(ce_i) && $past(phase_shift_select) == `PLPC_MODE_1X6) |-> led_pwm_o == {6{led_pwm_o[0]}};
  endproperty
  a_in_phase: assert property (p_in_phase) else $error("outputs not in phase");

  // Lowest code advances phase by four base steps
  property p_rate_low;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && $past(ce_i) && !$past(reset_i) && $past(dimming_frequency_select) == 4'h0)
      |-> acc == $past(acc) + `PLPC_ACC_W'(64'd4 * `PLPC_PHASE_STEP);
  endproperty
  a_rate_low: assert property (p_rate_low) else $error("code 0 rate wrong");

  // Highest code advances phase by thirty-two base steps
  property p_rate_high;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && $past(ce_i) && !$past(reset_i) && $past(dimming_frequency_select) == 4'hf)
      |-> acc == $past(acc) + `PLPC_ACC_W'(64'd32 * `PLPC_PHASE_STEP);
  endproperty
  a_rate_high: assert property (p_rate_high) else $error("code f rate wrong");

  // Bypass copies raw PWM onto the used drivers a cycle later
  property p_direct;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && $past(ce_i) && !$past(reset_i) && $past(direct_pwm))
      |-> led_pwm_o == ({6{$past(pwm_direct_i)}} & $past(chan_mask));
  endproperty
  a_direct: assert property (p_direct) else $error("bypass output wrong");

  // 1250 kHz: clock stays high eight cycles
  property p_boost_half;
    @(posedge clk_i) disable iff (reset_i)
      ($rose(boost_clk_o) && rate_sel == `PLPC_RATE_1250) ##0 (ce_i && rate_sel == `PLPC_RATE_1250) [*8]
      |=> $fell(boost_clk_o);
  endproperty
  a_boost_half: assert property (p_boost_half) else $error("boost half period wrong");

  // Voltage code and floor flag follow config and adaptive input
  property p_voltage;
    @(posedge clk_i) disable iff (reset_i)
      (ce_i && !$past(reset_i) && $past(ce_i)) |-> (boost_voltage_floor_o == $past(adaptive_enable_i))
      && (boost_voltage_target_o == $past(boost_setting_config[`PLPC_BVT_MSB:`PLPC_BVT_LSB]));
  endproperty
  a_voltage: assert property (p_voltage) else $error("boost voltage output wrong");
endmodule
`default_nettype wire

// ---- test/plpc_led_sinks.sv ----
// Behavioural model of the six LED current sinks fed by the PWM outputs.
// Assumes one clock shared with the block; watches driver 0 turn-on edges.
`timescale 1ns/1ps
`default_nettype none
module plpc_led_sinks (
  input wire logic clk_i, // System clock
  input wire logic reset_i, // Synchronous reset, high
  input wire logic [5:0] led_pwm_i, // Driver PWM inputs
  output logic [31:0] period_o, // Cycles between driver 0 turn-ons
  output logic [31:0] rises_o // Driver 0 turn-on count
);
  logic prev; // Driver 0 level one cycle ago
  logic [31:0] cnt; // Cycles since last turn-on
  // Sink turn-on timing; a sink only reacts to edges, so level alone tells nothing
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prev <= 1'b0;
      cnt <= 32'h0;
      period_o <= 32'h0;
      rises_o <= 32'h0;
    end else begin
      prev <= led_pwm_i[0];
      if (led_pwm_i[0] && !prev) begin // New frame on driver 0
        period_o <= cnt;
        cnt <= 32'h1;
        rises_o <= rises_o + 32'h1;
      end else begin
        cnt <= cnt + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/test_phased_led_pwm_config.sv ----
// Self-checking bench for the phased LED PWM configuration block.
// Assumes a 20 MHz clock, Avalon-MM register access and the sink model beside it.
`timescale 1ns/1ps
`default_nettype none
module test_phased_led_pwm_config;
  logic clk_i = 1'b0; // System clock
  logic reset_i = 1'b1; // Synchronous reset
  logic ce_i = 1'b1; // Kept running except in t_ce
  logic [9:0] avs_address_i = 10'h0; // Bus address
  logic avs_read_i = 1'b0; // Bus read
  logic avs_write_i = 1'b0; // Bus write
  logic [3:0] avs_byteenable_i = 4'h0; // Byte lanes
  logic [31:0] avs_writedata_i = 32'h0; // Write data
  logic [31:0] avs_readdata_o; // Read data
  logic avs_waitrequest_o; // Stall
  logic [9:0] duty_i = 10'h200; // Brightness
  logic pwm_direct_i = 1'b0; // Raw bypass PWM
  logic resistor_rate_enable_i = 1'b0; // Resistor rate select
  logic [1:0] resistor_rate_i = 2'h0; // Resistor rate code
  logic adaptive_enable_i = 1'b0; // Adaptive voltage
  logic [5:0] led_pwm_o; // Driver outputs
  logic boost_clk_o; // Boost clock
  logic [5:0] boost_voltage_target_o; // Voltage code
  logic boost_voltage_floor_o; // Code is floor
  logic [31:0] period_o; // Sink-measured frame length
  logic [31:0] rises_o; // Sink-seen frames
  int bad_count = 0; // Mismatches
  int tests_run = 0; // Comparisons
  logic [31:0] rd; // Last read data
  int h; // Measured half period
  localparam logic [9:0] A_PWM = 10'h294; // Output config byte address
  localparam logic [9:0] A_BST = 10'h298; // Boost config byte address
  plpc_top u_plpc_top (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .duty_i(duty_i), .pwm_direct_i(pwm_direct_i), .resistor_rate_enable_i(resistor_rate_enable_i),
    .resistor_rate_i(resistor_rate_i), .adaptive_enable_i(adaptive_enable_i), .led_pwm_o(led_pwm_o),
    .boost_clk_o(boost_clk_o), .boost_voltage_target_o(boost_voltage_target_o),
    .boost_voltage_floor_o(boost_voltage_floor_o));
  plpc_led_sinks u_plpc_led_sinks (.clk_i(clk_i), .reset_i(reset_i), .led_pwm_i(led_pwm_o),
    .period_o(period_o), .rises_o(rises_o));
  // Clock
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // Value compare; four-state so unknowns never match
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // Count compare with tolerance, for measured periods
  task automatic chk_near(input int got, input int exp, input int tol, input string msg);
    tests_run++;
    if (got < exp - tol || got > exp + tol) begin
      bad_count++;
      $display("[FAIL] %0t %s got %0d exp %0d", $time, msg, got, exp);
    end
  endtask
  // Bus cycle; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d, input logic be);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_byteenable_i <= {3'h0, be};
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 50) chk(32'h1, 32'h0, "bus hang");
  endtask
  // Reset values, read-back, refused writes, unmapped place
  task automatic t_regs;
    bus(1'b0, A_PWM, 8'h0, 1'b1);
    chk(rd, 32'h0, "pwm cfg reset");
    bus(1'b0, A_BST, 8'h0, 1'b1);
    chk(rd, 32'h0, "boost cfg reset");
    bus(1'b1, A_PWM, 8'h3c, 1'b1);
    bus(1'b0, A_PWM, 8'h0, 1'b1);
    chk(rd, 32'h3c, "pwm cfg rw");
    bus(1'b1, A_BST, 8'h81, 1'b1);
    bus(1'b0, A_BST, 8'h0, 1'b1);
    chk(rd, 32'h81, "boost cfg rw");
    bus(1'b1, A_PWM, 8'hff, 1'b0);
    bus(1'b0, A_PWM, 8'h0, 1'b1);
    chk(rd, 32'h3c, "lane off write");
    bus(1'b1, 10'h29c, 8'h55, 1'b1);
    bus(1'b0, 10'h29c, 8'h0, 1'b1);
    chk(rd, 32'h0, "unmapped");
  endtask
  // All eight phase modes: lit drivers, grouping and phase spread
  task automatic t_phase;
    logic [5:0] acc;
    logic [5:0] l;
    logic grp_bad;
    logic dif;
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, A_PWM, {1'b0, m[2:0], 4'hf}, 1'b1);
      repeat (4) @(posedge clk_i);
      acc = 6'h0;
      grp_bad = 1'b0;
      dif = 1'b0;
      repeat (600) begin
        @(posedge clk_i);
        l = led_pwm_o;
        acc = acc | l;
        if (m == 5 && (l[0] !== l[1] || l[2] !== l[3] || l[4] !== l[5])) grp_bad = 1'b1;
        if (m == 6 && (l[2:0] !== {3{l[0]}} || l[5:3] !== {3{l[3]}})) grp_bad = 1'b1;
        if (m == 7 && l !== {6{l[0]}}) grp_bad = 1'b1;
        if ((m < 5) ? (l[0] !== l[1]) : (l[0] !== l[5])) dif = 1'b1;
      end
      chk({26'h0, acc}, (m < 5) ? (32'h3f >> m) : 32'h3f, "lit drivers");
      chk({31'h0, grp_bad}, 32'h0, "group mismatch");
      chk({31'h0, dif}, (m == 7) ? 32'h0 : 32'h1, "phase spread");
    end
  endtask
  // Frame rate read from the sink model for one frequency code
  task automatic t_freq(input logic [3:0] code, input int hz);
    int n;
    int r0;
    bus(1'b1, A_PWM, {4'h7, code}, 1'b1);
    r0 = rises_o;
    n = 0;
    while (rises_o < r0 + 3 && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20000) chk(32'h1, 32'h0, "frame wait hang");
    chk_near(period_o, 20000000 / hz, 20000000 / hz / 100 + 2, "pwm frame length");
  endtask
  // Resolution: duty bits below the class width are dropped
  task automatic t_res(input logic [3:0] code, input logic [9:0] d, input logic lit);
    logic seen;
    duty_i <= d;
    bus(1'b1, A_PWM, {4'h7, code}, 1'b1);
    repeat (4) @(posedge clk_i);
    seen = 1'b0;
    repeat (4300) begin
      @(posedge clk_i);
      seen = seen | led_pwm_o[0];
    end
    chk({31'h0, seen}, {31'h0, lit}, "resolution");
  endtask
  // Bypass: raw PWM appears on lit drivers one cycle on
  task automatic t_direct;
    duty_i <= 10'h0;
    bus(1'b1, A_PWM, 8'hb0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      pwm_direct_i <= i[0];
      @(posedge clk_i);
      @(posedge clk_i);
      chk({26'h0, led_pwm_o}, {29'h0, {3{i[0]}}}, "direct pwm");
    end
  endtask
  // Half period of the boost clock
  task automatic meas_half(output int hp);
    logic v;
    int n;
    n = 0;
    @(posedge clk_i);
    v = boost_clk_o;
    while (boost_clk_o === v && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    v = boost_clk_o;
    hp = 0;
    while (boost_clk_o === v && hp < 200) begin
      @(posedge clk_i);
      hp++;
    end
  endtask
  // Boost rates, undefined code, resistor override, voltage code and floor flag
  task automatic t_boost;
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, A_BST, {r[1:0], 6'h2a}, 1'b1);
      meas_half(h);
      chk(h, (r == 3) ? 32 : (32 >> r), "boost half period");
    end
    chk({26'h0, boost_voltage_target_o}, 32'h2a, "voltage code");
    bus(1'b1, A_BST, 8'h15, 1'b1);
    resistor_rate_enable_i <= 1'b1;
    resistor_rate_i <= 2'h2;
    adaptive_enable_i <= 1'b1;
    meas_half(h);
    chk(h, 8, "resistor rate");
    chk({26'h0, boost_voltage_target_o}, 32'h15, "voltage update");
    chk({31'h0, boost_voltage_floor_o}, 32'h1, "floor flag");
  endtask
  // Clock enable low freezes drivers, boost clock and the bus handshake
  task automatic t_ce;
    logic [5:0] l;
    logic b;
    ce_i <= 1'b0;
    @(posedge clk_i);
    l = led_pwm_o;
    b = boost_clk_o;
    repeat (40) begin
      @(posedge clk_i);
      chk({26'h0, led_pwm_o}, {26'h0, l}, "frozen drivers");
      chk({31'h0, boost_clk_o}, {31'h0, b}, "frozen boost");
      chk({31'h0, avs_waitrequest_o}, 32'h1, "frozen bus");
    end
    ce_i <= 1'b1;
  endtask
  // Verdict and end of run
  task automatic conclude;
    if (bad_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    t_regs;
    t_phase;
    t_freq(4'h0, 4808);
    t_freq(4'h5, 12020);
    t_freq(4'hf, 38464);
    t_res(4'h0, 10'h001, 1'b1);
    t_res(4'h5, 10'h001, 1'b0);
    t_res(4'h5, 10'h002, 1'b1);
    t_res(4'hc, 10'h003, 1'b0);
    t_direct;
    t_boost;
    t_ce;
    conclude;
  end
  // Watchdog over the expected run length
  initial begin
    #4000000;
    bad_count++;
    conclude;
  end
endmodule
`default_nettype wire
